// ### inc/swm_regs.vh
// Timing counts, command codes and operation encodings of the single-wire bus master.
`ifndef SWM_REGS_VH
`define SWM_REGS_VH

// System clock and the one-microsecond tick derived from it.
`define SWM_CLK_HZ 20000000
`define SWM_TICK_CYC (`SWM_CLK_HZ / 1000000)

// Line timing in microseconds.
`define SWM_T_RST_LOW_US 10'd480
`define SWM_T_PRES_SAMPLE_US 10'd70
`define SWM_T_RST_HIGH_US 10'd480
`define SWM_T_W1_LOW_US 10'd6
`define SWM_T_W0_LOW_US 10'd60
`define SWM_T_RD_LOW_US 10'd2
`define SWM_T_RD_SAMPLE_US 10'd12
`define SWM_T_SLOT_US 10'd65
`define SWM_T_REC_US 10'd2

// User operations.
`define SWM_OP_RESET 3'h0
`define SWM_OP_WR_BYTE 3'h1
`define SWM_OP_RD_BYTE 3'h2
`define SWM_OP_WR_BIT 3'h3
`define SWM_OP_RD_BIT 3'h4
`define SWM_OP_CRC_CLR 3'h5

// Function command codes of the device; the master watches only the convert, copy and commit token codes.
`define SWM_CMD_CONVERT 8'h44
`define SWM_CMD_READ_SP1 8'hBE
`define SWM_CMD_READ_SP2 8'hAA
`define SWM_CMD_WRITE_SP2 8'h0F
`define SWM_CMD_COPY_SP2 8'h55
`define SWM_CMD_COPY_TOKEN 8'hA5
`define SWM_CMD_READ_MEM 8'hF0
`define SWM_CMD_READ_PSU 8'hB4
`define SWM_LOCK_VALUE 8'h55
`define SWM_LOCK_LOW_ADDR 8'h80
`define SWM_LOCK_HIGH_ADDR 8'h81

// CRC feedback constant for the reflected polynomial.
`define SWM_CRC_POLY 8'h8C
`define SWM_CRC_INIT 8'h00

`endif

// ### logic/swm_buf2.v
// Two-entry buffer with valid and ready on both sides and registered outputs.
module swm_buf2 (
  input wire clk,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [7:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [7:0] out_data
);

  reg [7:0] head_reg;
  reg [7:0] tail_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;

  // Full means two words held; the filling side then stalls.
  assign in_ready = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign out_data = head_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // The head always holds the oldest word, the tail the second one.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      head_reg <= 8'h00;
      tail_reg <= 8'h00;
      count_reg <= 2'd0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count_reg == 2'd0) begin
            head_reg <= in_data;
          end else begin
            tail_reg <= in_data;
          end
          count_reg <= count_reg + 2'd1;
        end
        2'b01: begin
          head_reg <= tail_reg;
          count_reg <= count_reg - 2'd1;
        end
        2'b11: begin
          if (count_reg == 2'd1) begin
            head_reg <= in_data;
          end else begin
            head_reg <= tail_reg;
            tail_reg <= in_data;
          end
        end
        default: begin
          count_reg <= count_reg;
        end
      endcase
    end
  end

endmodule // swm_buf2

// ### logic/swm_master.v
// Single-wire bus master: reset, bit slots, byte shifting, CRC and strong pullup control.
`include "swm_regs.vh"

module swm_master (
  input wire clk,
  input wire rstn,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [2:0] cmd_op,
  input wire [7:0] cmd_data,
  input wire parasite_mode,
  output wire rd_valid,
  input wire rd_ready,
  output wire [7:0] rd_data,
  output wire done,
  output wire presence,
  output wire [7:0] crc,
  output wire spu_en,
  input wire dq_in,
  output wire dq_out,
  output wire dq_oe
);

  localparam [6:0] ST_IDLE = 7'b0000001;
  localparam [6:0] ST_RST_LOW = 7'b0000010;
  localparam [6:0] ST_RST_HIGH = 7'b0000100;
  localparam [6:0] ST_SLOT = 7'b0001000;
  localparam [6:0] ST_NEXT = 7'b0010000;
  localparam [6:0] ST_PUSH = 7'b0100000;
  localparam [6:0] ST_DONE = 7'b1000000;
  localparam integer TICK_CYC = `SWM_TICK_CYC;
  localparam [4:0] TICK_LAST = TICK_CYC[4:0] - 5'd1;

  reg [6:0] state_reg;
  reg [6:0] state_next;
  reg [4:0] div_reg;
  reg tick_reg;
  reg [9:0] us_reg;
  reg sync1_reg;
  reg sync2_reg;
  reg [7:0] shift_reg;
  reg [2:0] bit_reg;
  reg byte_mode_reg;
  reg read_mode_reg;
  reg sample_reg;
  reg [7:0] crc_reg;
  reg [9:0] low_len_reg;
  reg cmd_ready_reg;
  reg done_reg;
  reg presence_reg;
  reg spu_reg;
  reg dq_oe_reg;
  reg dq_out_reg;
  reg copy_armed_reg;
  wire take;
  wire buf_in_ready;
  wire [7:0] push_data;

  // One bit of the reflected CRC; the same step serves sent and received bits.
  function [7:0] crc_step;
    input [7:0] c;
    input b;
    begin
      crc_step = (c[0] ^ b) ? ((c >> 1) ^ `SWM_CRC_POLY) : (c >> 1);
    end
  endfunction

  // Length of the low phase that opens a slot for the current bit.
  function [9:0] low_len;
    input rd;
    input b;
    begin
      if (rd) begin
        low_len = `SWM_T_RD_LOW_US;
      end else if (b) begin
        low_len = `SWM_T_W1_LOW_US;
      end else begin
        low_len = `SWM_T_W0_LOW_US;
      end
    end
  endfunction

  assign take = cmd_valid && cmd_ready_reg;
  assign push_data = byte_mode_reg ? shift_reg : {7'h00, sample_reg};
  assign cmd_ready = cmd_ready_reg;
  assign done = done_reg;
  assign presence = presence_reg;
  assign crc = crc_reg;
  assign spu_en = spu_reg;
  assign dq_oe = dq_oe_reg;
  assign dq_out = dq_out_reg;

  // Read results wait here so that a stalled receiver loses no word.
  swm_buf2 u_buf (
    .clk(clk),
    .rstn(rstn),
    .in_valid(state_reg == ST_PUSH),
    .in_ready(buf_in_ready),
    .in_data(push_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // Two flip-flops bring the bus line into the clock domain.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= dq_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Microsecond tick, restarted with each timed phase so phases begin cleanly.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 5'd0;
      tick_reg <= 1'b0;
    end else if (state_reg != state_next) begin
      div_reg <= 5'd0;
      tick_reg <= 1'b0;
    end else if (div_reg == TICK_LAST) begin
      div_reg <= 5'd0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 5'd1;
      tick_reg <= 1'b0;
    end
  end

  // Next state of the sequencer.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          case (cmd_op)
            `SWM_OP_RESET: state_next = ST_RST_LOW;
            `SWM_OP_WR_BYTE: state_next = ST_SLOT;
            `SWM_OP_RD_BYTE: state_next = ST_SLOT;
            `SWM_OP_WR_BIT: state_next = ST_SLOT;
            `SWM_OP_RD_BIT: state_next = ST_SLOT;
            default: state_next = ST_DONE;
          endcase
        end
      end
      ST_RST_LOW: begin
        if (tick_reg && us_reg == `SWM_T_RST_LOW_US - 10'd1) begin
          state_next = ST_RST_HIGH;
        end
      end
      ST_RST_HIGH: begin
        if (tick_reg && us_reg == `SWM_T_RST_HIGH_US - 10'd1) begin
          state_next = ST_DONE;
        end
      end
      ST_SLOT: begin
        if (tick_reg && us_reg == `SWM_T_SLOT_US + `SWM_T_REC_US - 10'd1) begin
          state_next = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (byte_mode_reg && bit_reg != 3'd7) begin
          state_next = ST_SLOT;
        end else if (read_mode_reg) begin
          state_next = ST_PUSH;
        end else begin
          state_next = ST_DONE;
        end
      end
      ST_PUSH: begin
        if (buf_in_ready) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State register, phase timer and the registered handshake outputs.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      us_reg <= 10'd0;
      cmd_ready_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_ready_reg <= (state_next == ST_IDLE);
      done_reg <= (state_reg == ST_DONE);
      if (state_reg != state_next) begin
        us_reg <= 10'd0;
      end else if (tick_reg) begin
        us_reg <= us_reg + 10'd1;
      end
    end
  end

  // Line drive: low during reset and the opening part of each slot, else released.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dq_oe_reg <= 1'b0;
      dq_out_reg <= 1'b0;
    end else begin
      dq_out_reg <= 1'b0;
      if (state_next == ST_RST_LOW) begin
        dq_oe_reg <= 1'b1;
      end else if (state_next == ST_SLOT && state_reg == ST_SLOT) begin
        dq_oe_reg <= (us_reg < low_len_reg);
      end else if (state_next == ST_SLOT) begin
        dq_oe_reg <= 1'b1;
      end else begin
        dq_oe_reg <= 1'b0;
      end
    end
  end

  // Bit shifting, sampling, presence detection and the running CRC.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= 8'h00;
      bit_reg <= 3'd0;
      byte_mode_reg <= 1'b0;
      read_mode_reg <= 1'b0;
      sample_reg <= 1'b0;
      crc_reg <= `SWM_CRC_INIT;
      low_len_reg <= 10'd0;
      presence_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            shift_reg <= cmd_data;
            bit_reg <= 3'd0;
            byte_mode_reg <= (cmd_op == `SWM_OP_WR_BYTE) || (cmd_op == `SWM_OP_RD_BYTE);
            read_mode_reg <= (cmd_op == `SWM_OP_RD_BYTE) || (cmd_op == `SWM_OP_RD_BIT);
            low_len_reg <= low_len((cmd_op == `SWM_OP_RD_BYTE) || (cmd_op == `SWM_OP_RD_BIT),
              cmd_data[0]);
            if (cmd_op == `SWM_OP_RESET || cmd_op == `SWM_OP_CRC_CLR) begin
              crc_reg <= `SWM_CRC_INIT;
            end
            if (cmd_op == `SWM_OP_RESET) begin
              presence_reg <= 1'b0;
            end
          end
        end
        ST_RST_HIGH: begin
          if (tick_reg && us_reg == `SWM_T_PRES_SAMPLE_US) begin
            presence_reg <= !sync2_reg;
          end
        end
        ST_SLOT: begin
          if (tick_reg && us_reg == `SWM_T_RD_SAMPLE_US && read_mode_reg) begin
            sample_reg <= sync2_reg;
          end
          if (tick_reg && us_reg == `SWM_T_RD_SAMPLE_US && !read_mode_reg) begin
            sample_reg <= shift_reg[0];
          end
        end
        ST_NEXT: begin
          if (byte_mode_reg) begin
            crc_reg <= crc_step(crc_reg, sample_reg);
            if (read_mode_reg) begin
              shift_reg <= {sample_reg, shift_reg[7:1]};
            end else begin
              shift_reg <= {shift_reg[0], shift_reg[7:1]};
              low_len_reg <= low_len(1'b0, shift_reg[1]);
            end
            if (bit_reg != 3'd7) begin
              bit_reg <= bit_reg + 3'd1;
            end
          end
        end
        default: begin
          bit_reg <= bit_reg;
        end
      endcase
    end
  end

  // Strong pullup after a conversion start or a commit token on a parasite-powered bus.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spu_reg <= 1'b0;
      copy_armed_reg <= 1'b0;
    end else begin
      if (take) begin
        spu_reg <= 1'b0;
      end else if (state_reg == ST_DONE && byte_mode_reg && !read_mode_reg && parasite_mode &&
          (shift_reg == `SWM_CMD_CONVERT || (copy_armed_reg &&
          shift_reg == `SWM_CMD_COPY_TOKEN))) begin
        spu_reg <= 1'b1;
      end
      if (take && cmd_op == `SWM_OP_RESET) begin
        copy_armed_reg <= 1'b0;
      end else if (state_reg == ST_DONE && byte_mode_reg && !read_mode_reg) begin
        copy_armed_reg <= (shift_reg == `SWM_CMD_COPY_SP2);
      end
    end
  end

endmodule // swm_master

// ### verif/swm_checker.sv
// Concurrent checks on the ports of the single-wire bus master.
`include "swm_regs.vh"

module swm_checker (
  input wire clk,
  input wire rstn,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [2:0] cmd_op,
  input wire [7:0] cmd_data,
  input wire parasite_mode,
  input wire done,
  input wire [7:0] crc,
  input wire spu_en,
  input wire dq_out,
  input wire dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = `SWM_TICK_CYC;
  logic [2:0] op_reg;
  logic [7:0] data_reg;
  logic [13:0] low_len_reg;
  logic [13:0] idle_len_reg;
  logic [13:0] gap_len_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Keep the last request and time the pulled, released and slot-to-slot spans of the line.
  // Idle and gap start saturated so the first pull after reset never looks too close.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_reg <= 3'h0;
      data_reg <= 8'h00;
      low_len_reg <= 14'h0000;
      idle_len_reg <= 14'h3fff;
      gap_len_reg <= 14'h3fff;
    end else begin
      if (cmd_valid && cmd_ready) begin
        op_reg <= cmd_op;
        data_reg <= cmd_data;
      end
      low_len_reg <= dq_oe ? low_len_reg + 14'h0001 : 14'h0000;
      idle_len_reg <= dq_oe ? 14'h0000 : idle_len_reg + {13'h0000, idle_len_reg != 14'h3fff};
      if (dq_oe && low_len_reg == 14'h0000) begin
        gap_len_reg <= 14'h0001;
      end else begin
        gap_len_reg <= gap_len_reg + {13'h0000, gap_len_reg != 14'h3fff};
      end
    end
  end

  // A request taken, and the moment the master lets go of the line.
  sequence s_take(logic [2:0] op);
    cmd_valid && cmd_ready && cmd_op == op;
  endsequence
  sequence s_release;
    $fell(dq_oe);
  endsequence

  property p_rst_low;
    s_release ##0 (op_reg == `SWM_OP_RESET) |-> low_len_reg >= 480 * TICK;
  endproperty
  property p_wr1_low;
    s_release ##0 (op_reg == `SWM_OP_WR_BIT && data_reg[0])
      |-> low_len_reg >= TICK && low_len_reg < 15 * TICK;
  endproperty
  property p_wr0_low;
    s_release ##0 (op_reg == `SWM_OP_WR_BIT && !data_reg[0]) |-> low_len_reg >= 60 * TICK;
  endproperty
  property p_rd_low;
    s_release ##0 (op_reg == `SWM_OP_RD_BIT || op_reg == `SWM_OP_RD_BYTE)
      |-> low_len_reg >= TICK && low_len_reg < 15 * TICK;
  endproperty
  property p_recovery;
    $rose(dq_oe) |-> idle_len_reg >= TICK;
  endproperty
  property p_slot_len;
    $rose(dq_oe) |-> gap_len_reg >= 61 * TICK;
  endproperty
  property p_busy;
    cmd_valid && cmd_ready |=> !cmd_ready;
  endproperty
  property p_clr_crc;
    s_take(`SWM_OP_CRC_CLR) |-> ##2 (done && crc == 8'h00);
  endproperty
  property p_spu_set;
    done && parasite_mode && op_reg == `SWM_OP_WR_BYTE && data_reg == `SWM_CMD_CONVERT
      |-> ##[0:1] spu_en;
  endproperty
  property p_spu_quiet;
    spu_en |-> !dq_oe && parasite_mode;
  endproperty
  property p_od_drive;
    dq_oe |-> !dq_out;
  endproperty

  a_rst_low: assert property (p_rst_low) else $error("reset pulse too short");
  a_wr1_low: assert property (p_wr1_low) else $error("write-one low time wrong");
  a_wr0_low: assert property (p_wr0_low) else $error("write-zero low too short");
  a_rd_low: assert property (p_rd_low) else $error("read slot low time wrong");
  a_recovery: assert property (p_recovery) else $error("recovery too short");
  a_slot_len: assert property (p_slot_len) else $error("slot too short");
  a_busy: assert property (p_busy) else $error("ready after take");
  a_clr_crc: assert property (p_clr_crc) else $error("crc clear wrong");
  a_spu_set: assert property (p_spu_set) else $error("strong pullup missing");
  a_spu_quiet: assert property (p_spu_quiet) else $error("traffic under pullup");
  a_od_drive: assert property (p_od_drive) else $error("line driven high");
endmodule // swm_checker

// ### verif/swm_dev_model.sv
// Behavioural model of the sensor's bit-level behaviour on the shared line.
module swm_dev_model (
  input wire logic dq,
  input wire logic present_en,
  input wire logic tx_en,
  input wire logic [7:0] tx_byte,
  output logic pull,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int US = 1000;
  int slot_idx;
  realtime t_fall;
  logic s;

  // Each falling edge from the master opens a slot or a reset pulse; the pullup restores high.
  initial begin
    pull = 1'b0;
    rx_byte = 8'h00;
    slot_idx = 0;
    forever begin
      @(negedge dq);
      t_fall = $realtime;
      pull = tx_en && !tx_byte[slot_idx % 8];
      #(15 * US) pull = 1'b0;
      #(15 * US) s = dq;
      wait (dq === 1'b1);
      if ($realtime - t_fall >= 470 * US) begin
        slot_idx = 0;
        #(30 * US) pull = present_en;
        #(120 * US) pull = 1'b0;
      end else begin
        rx_byte = {s, rx_byte[7:1]};
        slot_idx++;
      end
    end
  end
endmodule // swm_dev_model

// ### verif/swm_master_tb_top.sv
// Self-checking testbench of the single-wire bus master against the sensor model.
`include "swm_regs.vh"

module swm_master_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, cmd_valid, parasite_mode, rd_ready, present_en, tx_en, dev_pull;
  logic [2:0] cmd_op;
  logic [7:0] cmd_data, tx_byte, rx_byte, rd_data, crc, exp_crc;
  wire cmd_ready, rd_valid, done, presence, spu_en, dq_out, dq_oe;
  wire dq_line;
  int fail_count = 0;
  int comparisons = 0;

  // The line is pulled up and low whenever either party pulls it.
  assign dq_line = !(dq_oe | dev_pull);

  swm_master u_dut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .parasite_mode(parasite_mode), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .done(done), .presence(presence), .crc(crc),
    .spu_en(spu_en), .dq_in(dq_line), .dq_out(dq_out), .dq_oe(dq_oe));
  swm_dev_model u_dev (.dq(dq_line), .present_en(present_en), .tx_en(tx_en),
    .tx_byte(tx_byte), .pull(dev_pull), .rx_byte(rx_byte));

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Reflected CRC step over one byte, least significant bit first.
  function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int k = 0; k < 8; k++) r = (r >> 1) ^ ((r[0] ^ b[k]) ? 8'h8C : 8'h00);
    return r;
  endfunction

  // Issue one request, hold it until taken, then wait for its done pulse.
  task automatic run_op(input logic [2:0] op, input logic [7:0] d, input int lim);
    int i;
    @(negedge clk);
    cmd_op = op;
    cmd_data = d;
    cmd_valid = 1'b1;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 100) begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && i < lim) begin
      @(negedge clk);
      i++;
    end
    if (done !== 1'b1) begin
      check("op completion", 8'h01, 8'h00);
      stop_test;
    end
  endtask

  // Wait for a buffered word, compare it and pop it.
  task automatic pop(input logic [7:0] exp);
    int i;
    i = 0;
    while (rd_valid !== 1'b1 && i < 3000) begin
      @(negedge clk);
      i++;
    end
    check("rd_valid", 8'h01, {7'h00, rd_valid});
    check("rd_data", exp, rd_data);
    rd_ready = 1'b1;
    @(negedge clk);
    rd_ready = 1'b0;
    @(negedge clk);
  endtask

  task automatic sc_reset(input logic en);
    present_en = en;
    run_op(`SWM_OP_RESET, 8'h00, 21000);
    check("presence", {7'h00, en}, {7'h00, presence});
    check("crc after reset", 8'h00, crc);
  endtask

  task automatic sc_convert_and_read;
    parasite_mode = 1'b1;
    run_op(`SWM_OP_WR_BYTE, `SWM_CMD_CONVERT, 12000);
    exp_crc = crc_byte(8'h00, 8'h44);
    check("device byte", 8'h44, rx_byte);
    @(negedge clk);
    check("spu_en", 8'h01, {7'h00, spu_en});
    tx_byte = 8'h3C;
    tx_en = 1'b1;
    run_op(`SWM_OP_RD_BYTE, 8'h00, 12000);
    check("spu_en cleared", 8'h00, {7'h00, spu_en});
    pop(8'h3C);
    exp_crc = crc_byte(exp_crc, 8'h3C);
    check("crc", exp_crc, crc);
  endtask

  // Two read bits fill the buffer; a third must stall until the user pops a word from it.
  task automatic sc_buffer;
    tx_byte = 8'h05;
    run_op(`SWM_OP_RD_BIT, 8'h00, 2000);
    run_op(`SWM_OP_RD_BIT, 8'h00, 2000);
    fork
      run_op(`SWM_OP_RD_BIT, 8'h00, 6000);
      begin
        repeat (2000) @(negedge clk);
        check("stalled ready", 8'h00, {7'h00, cmd_ready});
        pop(8'h01);
        pop(8'h00);
        pop(8'h01);
      end
    join
  endtask

  task automatic sc_bits_and_clear;
    tx_en = 1'b0;
    run_op(`SWM_OP_WR_BIT, 8'h00, 2000);
    run_op(`SWM_OP_WR_BIT, 8'h01, 2000);
    check("written bits", 8'h02, {6'h00, rx_byte[7:6]});
    run_op(`SWM_OP_CRC_CLR, 8'h00, 10);
    check("crc cleared", 8'h00, crc);
  endtask

  // A commit token straight after the copy command raises the strong pullup.
  task automatic sc_copy;
    run_op(`SWM_OP_WR_BYTE, `SWM_CMD_COPY_SP2, 12000);
    check("spu_en after copy", 8'h00, {7'h00, spu_en});
    run_op(`SWM_OP_WR_BYTE, `SWM_CMD_COPY_TOKEN, 12000);
    check("device token", 8'hA5, rx_byte);
    @(negedge clk);
    check("spu_en after token", 8'h01, {7'h00, spu_en});
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_data = 8'h00;
    parasite_mode = 1'b0;
    rd_ready = 1'b0;
    present_en = 1'b0;
    tx_en = 1'b0;
    tx_byte = 8'h00;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    sc_reset(1'b0);
    sc_reset(1'b1);
    sc_convert_and_read;
    sc_buffer;
    sc_bits_and_clear;
    sc_copy;
    stop_test;
  end
endmodule // swm_master_tb_top

bind swm_master swm_checker u_chk (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .parasite_mode(parasite_mode),
  .done(done), .crc(crc), .spu_en(spu_en), .dq_out(dq_out), .dq_oe(dq_oe));
